// *** hw/ppfs_sequencer.sv ***
// push-pull gate sequencer with dead-time marker, soft start and retry
//
// How it works
// - marker low in lockout, over-current shutdown or when not switching
// - while switching, marker is high exactly during the discharge phase
// - both gates stay low for the whole discharge phase
// - a toggle stage steers pulses alternately to the two gates
// - each gate pulses once per two oscillator cycles
// - over-current ends the pulse at once and forces zero duty
// - first gate pulse comes 59 oscillator cycles after start or release
// - soft start lasts five cycles before the first full-width pulse
// - soft start moves the leading edge; trailing edge stays at discharge
// - after any fault, gates and marker stay dark at least 56 cycles
// - switching starts on supply-good and stops when it drops
// - full recovery after fault release takes 64 oscillator cycles
// - marker resumes two cycles before the first gate pulse
`timescale 1ns/1ps
`default_nettype none

module ppfs_sequencer
  import ppfs_pkg::*;
#(
  parameter int unsigned LOCK_N = LOCK_CYCLES,
  parameter int unsigned LEAD_N = LEAD_CYCLES,
  parameter int unsigned SS_N   = SS_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // oscillator and fault comparators, asynchronous pins
  input  wire logic discharge_node_i,
  input  wire logic overcurrent_i,
  input  wire logic supply_good_i,
  // gate drives and dead-time marker
  output logic      drive_out_first_o,
  output logic      drive_out_second_o,
  output logic      dead_time_marker_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_filt;

  assign pin_raw[PIN_DIS] = discharge_node_i;
  assign pin_raw[PIN_OC]  = overcurrent_i;
  assign pin_raw[PIN_SUP] = supply_good_i;

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_pin
      logic [SYNC_STAGES-1:0] sh_q;
      logic [SYNC_STAGES-1:0] sh_d;
      logic                   filt_q;
      logic                   filt_d;
      // shift in; first stage is read only by the second
      always_comb begin
        sh_d   = {sh_q[SYNC_STAGES-2:0], pin_raw[gi]};
        filt_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : filt_q;
      end
      // each pin keeps its own filtered level, one process per bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          sh_q   <= '0;
          filt_q <= 1'b0;
        end else begin
          sh_q   <= sh_d;
          filt_q <= filt_d;
        end
      end
      assign pin_filt[gi] = filt_q;
    end
  endgenerate

  logic dis_s;
  logic oc_s;
  logic sup_s;
  assign dis_s = pin_filt[PIN_DIS];
  assign oc_s  = pin_filt[PIN_OC];
  assign sup_s = pin_filt[PIN_SUP];

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  ppfs_state_e        state_q,     state_d;
  logic [CYC_W-1:0]   cyc_q,       cyc_d;
  logic               dis_prev_q,  dis_prev_d;
  logic               steer_q,     steer_d;
  logic [PHASE_W-1:0] elapsed_q,   elapsed_d;
  logic [PHASE_W-1:0] chg_len_q,   chg_len_d;
  logic               first_q,     first_d;
  logic               second_q,    second_d;
  logic               marker_q,    marker_d;

  logic               cycle_end;
  logic               chg_end;
  logic [PHASE_W-1:0] lead_off;
  logic               gate_on;
  logic               switching;

  // next-state, counters and output terms
  always_comb begin
    state_d    = state_q;
    cyc_d      = cyc_q;
    dis_prev_d = dis_s;
    steer_d    = steer_q;
    chg_len_d  = chg_len_q;
    cycle_end  = dis_prev_q & ~dis_s;
    chg_end    = ~dis_prev_q & dis_s;
    // clk cycles since the charge phase began, saturating
    if (cycle_end) begin
      elapsed_d = '0;
    end else if (elapsed_q != '1) begin
      elapsed_d = elapsed_q + 1'b1;
    end else begin
      elapsed_d = elapsed_q;
    end
    if (chg_end) begin
      chg_len_d = elapsed_q;
    end
    // toggle stage flips once per oscillator cycle
    if (cycle_end) begin
      steer_d = ~steer_q;
    end

    case (state_q)
      PPFS_OFF: begin
        cyc_d = '0;
        if (sup_s) begin
          state_d = PPFS_LOCK;
        end
      end
      PPFS_FAULT: begin
        cyc_d = '0;
        if (!oc_s) begin
          state_d = PPFS_LOCK;
        end
      end
      PPFS_LOCK: begin
        if (cycle_end) begin
          if (cyc_q == CYC_W'(LOCK_N - 1)) begin
            cyc_d   = '0;
            state_d = PPFS_LEAD;
          end else begin
            cyc_d = cyc_q + 1'b1;
          end
        end
      end
      PPFS_LEAD: begin
        if (cycle_end) begin
          if (cyc_q == CYC_W'(LEAD_N - 1)) begin
            cyc_d   = '0;
            state_d = PPFS_SOFT;
          end else begin
            cyc_d = cyc_q + 1'b1;
          end
        end
      end
      PPFS_SOFT: begin
        if (cycle_end) begin
          if (cyc_q == CYC_W'(SS_N - 1)) begin
            cyc_d   = '0;
            state_d = PPFS_RUN;
          end else begin
            cyc_d = cyc_q + 1'b1;
          end
        end
      end
      PPFS_RUN: begin
        cyc_d = '0;
      end
      default: begin
        cyc_d   = '0;
        state_d = PPFS_OFF;
      end
    endcase

    // supply loss and over-current override any state
    if (!sup_s) begin
      state_d = PPFS_OFF;
    end else if (oc_s) begin
      state_d = PPFS_FAULT;
    end

    // leading-edge delay halves on each soft-start step
    lead_off = chg_len_q >> (cyc_q + 1'b1);
    switching = (state_d == PPFS_LEAD) || (state_d == PPFS_SOFT)
             || (state_d == PPFS_RUN);
    case (state_d)
      PPFS_SOFT: gate_on = !dis_s && (elapsed_d >= lead_off);
      PPFS_RUN:  gate_on = !dis_s;
      default:   gate_on = 1'b0;
    endcase
    first_d  = gate_on & ~steer_d;
    second_d = gate_on & steer_d;
    marker_d = switching & dis_s;
  end

  // registers of the sequencer and outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= PPFS_OFF;
      cyc_q      <= '0;
      dis_prev_q <= 1'b0;
      steer_q    <= 1'b0;
      elapsed_q  <= '0;
      chg_len_q  <= '0;
      first_q    <= 1'b0;
      second_q   <= 1'b0;
      marker_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      cyc_q      <= cyc_d;
      dis_prev_q <= dis_prev_d;
      steer_q    <= steer_d;
      elapsed_q  <= elapsed_d;
      chg_len_q  <= chg_len_d;
      first_q    <= first_d;
      second_q   <= second_d;
      marker_q   <= marker_d;
    end
  end

  assign drive_out_first_o  = first_q;
  assign drive_out_second_o = second_q;
  assign dead_time_marker_o = marker_q;

endmodule

`default_nettype wire

// *** hw/ppfs_pkg.sv ***
// shared constants of the push-pull fault sequencer
package ppfs_pkg;

  // ----------------------------------------------------------------------
  // sequencing counts, in oscillator cycles
  // ----------------------------------------------------------------------
  localparam int unsigned LOCK_CYCLES = 57; // dark interval after release
  localparam int unsigned LEAD_CYCLES = 2;  // marker-only cycles
  localparam int unsigned SS_CYCLES   = 5;  // partial-width pulses
  localparam int unsigned CYC_W       = 6;  // oscillator cycle counter

  // ----------------------------------------------------------------------
  // clock-rate counter and input synchroniser
  // ----------------------------------------------------------------------
  localparam int unsigned PHASE_W     = 16; // width of the clk-cycle phase counters
  localparam int unsigned SYNC_STAGES = 3;  // pin synchroniser depth
  localparam int unsigned N_PINS      = 3;  // discharge, over-current, supply
  localparam int unsigned PIN_DIS     = 0;
  localparam int unsigned PIN_OC      = 1;
  localparam int unsigned PIN_SUP     = 2;

  // sequencer states
  typedef enum logic [2:0] {
    PPFS_OFF,
    PPFS_FAULT,
    PPFS_LOCK,
    PPFS_LEAD,
    PPFS_SOFT,
    PPFS_RUN
  } ppfs_state_e;

endpackage

// *** verification/ppfs_checker.sv ***
// assertion checker for the push-pull fault sequencer
`timescale 1ns/1ps
`default_nettype none
module ppfs_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // oscillator and fault pins
  input wire logic discharge_node_i,
  input wire logic overcurrent_i,
  input wire logic supply_good_i,
  // gate drives and dead-time marker
  input wire logic drive_out_first_o,
  input wire logic drive_out_second_o,
  input wire logic dead_time_marker_o
);
  logic [5:0] cyc_q;
  logic [1:0] last_q;
  logic       dis_q;
  logic       gate;
  logic       dark;
  logic       both;
  logic       live;
  // helper terms over the watched pins and outputs
  assign gate = drive_out_first_o | drive_out_second_o;
  assign dark = !gate && !dead_time_marker_o;
  assign both = drive_out_first_o && drive_out_second_o;
  assign live = !overcurrent_i && supply_good_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // oscillator cycles since the last fault or supply loss ended, and last gate used
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_q  <= 6'h00;
      last_q <= 2'h0;
      dis_q  <= 1'b0;
    end else begin
      dis_q <= discharge_node_i;
      if (!live) begin
        cyc_q  <= 6'h00;
        last_q <= 2'h0;
      end else begin
        if (dis_q && !discharge_node_i && cyc_q != 6'h3f) begin
          cyc_q <= cyc_q + 6'h01;
        end
        if ($rose(drive_out_first_o)) begin
          last_q <= 2'h1;
        end
        if ($rose(drive_out_second_o)) begin
          last_q <= 2'h2;
        end
      end
    end
  end
  // a pin level takes three stages plus two registers to reach outputs
  sequence s_oc_held; overcurrent_i [*6]; endsequence
  sequence s_supply_gone; !supply_good_i [*6]; endsequence
  sequence s_marker_up; $rose(dead_time_marker_o); endsequence
  sequence s_first_up; $rose(drive_out_first_o); endsequence
  sequence s_second_up; $rose(drive_out_second_o); endsequence
  sequence s_gate_up; $rose(gate); endsequence
  a_oc_gates_off: assert property (s_oc_held |-> !gate)
    else $error("gate active during over-current");
  a_oc_marker_off: assert property (
    s_oc_held |-> !dead_time_marker_o)
    else $error("marker active during over-current");
  a_supply_dark: assert property (s_supply_gone |-> dark)
    else $error("outputs active without supply");
  a_gates_exclusive: assert property (!both)
    else $error("both gates high");
  a_dead_gates_low: assert property (dead_time_marker_o |-> !gate)
    else $error("gate high in dead time");
  a_marker_phase: assert property (
    s_marker_up |-> $past(discharge_node_i, 3))
    else $error("marker rose outside discharge");
  a_alt_first: assert property (s_first_up |-> last_q != 2'h1)
    else $error("first gate pulsed twice in a row");
  a_alt_second: assert property (s_second_up |-> last_q != 2'h2)
    else $error("second gate pulsed twice in a row");
  a_retry_dark: assert property (live && cyc_q < 6'd56 |-> dark)
    else $error("outputs active during lockout");
  a_first_late: assert property (s_gate_up |-> cyc_q >= 6'd57)
    else $error("gate pulse too early after release");
endmodule
bind ppfs_sequencer ppfs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .discharge_node_i(discharge_node_i), .overcurrent_i(overcurrent_i),
  .supply_good_i(supply_good_i), .drive_out_first_o(drive_out_first_o),
  .drive_out_second_o(drive_out_second_o),
  .dead_time_marker_o(dead_time_marker_o));
`default_nettype wire

// *** verification/ppfs_osc_model.sv ***
// oscillator model: charge and discharge phases of set lengths
`timescale 1ns/1ps
`default_nettype none
module ppfs_osc_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] chg_len_i,
  input  wire logic [7:0] dis_len_i,
  output logic            dis_o
);
  logic [7:0] cnt;
  // each end of discharge closes one oscillator cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      dis_o <= 1'b0;
    end else if (cnt + 8'h01 >= (dis_o ? dis_len_i : chg_len_i)) begin
      cnt <= 8'h00;
      dis_o <= ~dis_o;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the push-pull fault sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       clk_i = 1'b0, rst_i = 1'b1, oc = 1'b0, sup = 1'b0;
  logic [7:0] chg = 8'h40, dis = 8'h06;
  logic       dis_n, g1, g2, mk;
  int         mismatches = 0, num_checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  ppfs_osc_model osc (.clk_i(clk_i), .rst_i(rst_i), .chg_len_i(chg),
    .dis_len_i(dis), .dis_o(dis_n));
  ppfs_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .discharge_node_i(dis_n),
    .overcurrent_i(oc), .supply_good_i(sup), .drive_out_first_o(g1),
    .drive_out_second_o(g2), .dead_time_marker_o(mk));
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic in_range(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction
  // follow one recovery up to the first full-width gate pulse
  task automatic recover();
    int   n = 0, nr = 0, nf = -1, lead = 0, nsoft = 0, w = 0, prev = 0;
    int   m = 0;
    logic pd = 1'b0, mp = 1'b0, go = 1'b0, done = 1'b0;
    for (int t = 0; t < 9000 && !done; t++) begin
      @(posedge clk_i);
      if (pd && !dis_n) n++;
      if (mk && !mp && !go) lead++;
      pd = dis_n;
      mp = mk;
      if (g1 | g2) begin
        if (!go) nf = n;
        if (w == 0) nr = n;
        go = 1'b1;
        w++;
      end else if (w > 0) begin
        if (w >= chg) begin
          done = 1'b1;
        end else begin
          check(w >= prev, 1'b1);
          prev = w;
          nsoft++;
          w = 0;
        end
      end
    end
    check(done, 1'b1);
    check(in_range(nsoft, 4, 7), 1'b1);
    check(in_range(lead, 1, 2), 1'b1);
    check(in_range(nf, 57, 62), 1'b1);
    check(in_range(nr, 62, 65), 1'b1);
    // the marker spans the discharge that closes the full pulse
    while (mk && m < 300) begin
      m++;
      @(posedge clk_i);
    end
    check(m, dis);
  endtask
  // raise a fault, hold it, check the outputs are dark, release it
  task automatic fault(bit supply);
    if (supply) sup <= 1'b0;
    else oc <= 1'b1;
    repeat (12) @(posedge clk_i);
    check(g1 | g2 | mk, 1'b0);
    oc <= 1'b0;
    sup <= 1'b1;
  endtask
  // main sequence: start, random faults, fault at the first soft-start pulse
  initial begin
    void'($urandom(62));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(g1 | g2 | mk, 1'b0);
    sup <= 1'b1;
    recover();
    for (int e = 0; e < 3; e++) begin
      chg <= 8'h40 + 8'($urandom_range(0, 24));
      dis <= 8'($urandom_range(4, 10));
      repeat ($urandom_range(1, 300)) @(posedge clk_i);
      fault(e == 1);
      recover();
    end
    fault(1'b0);
    for (int t = 0; t < 9000 && !(g1 | g2); t++) @(posedge clk_i);
    check(g1 | g2, 1'b1);
    fault(1'b0);
    recover();
    close_out();
  end
  // watchdog against a hang
  initial begin
    #300000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
